//--- src/dcp_core.sv
// configuration port and full-rate sample output of the two-channel converter
//
// Contract
// R01: strap low: four pins form serial port
// R02: strap high: four pins are parallel mode inputs
// R03: convert both channels on encode rising edge
// R04: serial clock shifts only while select low
// R05: serial data sampled on serial clock rise
// R06: readback shifted out, host captures on fall
// R07: serial output is open drain, low or released
// R08: parallel: select level switches duty stabilizer
// R09: parallel: serial clock level picks output format
// R10: parallel: data in/out levels pick power state
// R11: buses and flags change on forwarded clock fall
// R12: forwarded clock phase delay set by register
// R13: negative forwarded clock always complements positive
// R14: twelve lines per channel, top line msb
// R15: overrange flag high on over/underflow sample
// R16: sample appears six encode cycles later
// R17: one aligned new sample per encode cycle
`timescale 1ns/1ns
module dcp_core #(
	parameter int BITS = dcp_pkg::SAMPLE_BITS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic programming_mode_strap,
	input wire logic encode_in_pos,
	input wire logic encode_in_neg,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_in,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic [BITS-1:0] conv1_data,
	input wire logic conv1_ovr,
	input wire logic [BITS-1:0] conv2_data,
	input wire logic conv2_ovr,
	output logic [BITS-1:0] chan1_sample_bus,
	output logic [BITS-1:0] chan2_sample_bus,
	output logic chan1_overrange_flag,
	output logic chan2_overrange_flag,
	output logic fwd_out_clock_pos,
	output logic fwd_out_clock_neg,
	input wire logic sample_ready,
	output logic sample_valid,
	output logic sample_lost,
	output logic parallel_mode,
	output logic dcs_on,
	output logic twos_complement,
	output logic [1:0] power_state
);

	localparam int W = 2 * BITS + 2;
	localparam int NP = dcp_pkg::PIPE_STAGES;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [1:0] cs_q;
		logic [1:0] sck_q;
		logic [1:0] sdi_q;
		logic [1:0] sdo_q;
		logic [1:0] encp_q;
		logic [1:0] encn_q;
		logic [1:0] strap_q;
		logic [1:0][W-1:0] conv_q;
		logic sck_d;
		logic enc_d;
		logic strap_done;
		logic [1:0] strap_cnt;
		logic par;
		dcp_pkg::dcp_ser_e ser;
		logic [2:0] bit_cnt;
		logic [6:0] shift;
		logic [6:0] addr;
		logic [7:0] rd_shift;
		logic sdo_low;
		logic [1:0] reg_power;
		logic reg_dcs;
		logic [1:0] reg_phase;
		logic reg_twos;
		logic [NP-1:0][W-1:0] pipe;
		logic [NP-1:0] pipe_vld;
		logic [W-1:0] out_word;
		logic out_vld;
		logic lost;
		logic [dcp_pkg::PHASE_TAPS-1:0] fwd_line;
	} dcp_core_s;

	dcp_core_s st;
	dcp_core_s next_st;

	logic cs_lvl;
	logic sck_lvl;
	logic sck_rise;
	logic sck_fall;
	logic enc_lvl;
	logic enc_rise;
	logic active;
	logic [7:0] rx_byte;
	logic [7:0] rd_value;
	logic [1:0] eff_phase;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [W-1:0] buf_out_data;

	// ****************************************
	// decoded levels and edges (second synchroniser stage only)
	// ****************************************
	assign cs_lvl = st.cs_q[1];
	assign sck_lvl = st.sck_q[1];
	assign sck_rise = sck_lvl & ~st.sck_d;
	assign sck_fall = ~sck_lvl & st.sck_d;
	// single-ended encode ties the negative leg low, so this covers both drives
	assign enc_lvl = st.encp_q[1] & ~st.encn_q[1];
	assign enc_rise = enc_lvl & ~st.enc_d; // R03
	assign rx_byte = {st.shift, st.sdi_q[1]}; // R05

	// parallel mode reads the pins as levels, serial mode the registers
	assign dcs_on = st.par ? cs_lvl : st.reg_dcs; // R08
	assign twos_complement = st.par ? sck_lvl : st.reg_twos; // R09
	assign power_state = st.par ? {st.sdi_q[1], st.sdo_q[1]} : st.reg_power; // R10
	assign eff_phase = st.par ? 2'h0 : st.reg_phase;
	assign parallel_mode = st.par;
	assign active = st.strap_done & (power_state == dcp_pkg::PWR_NORMAL);

	always_comb begin
		unique case (st.addr)
			dcp_pkg::ADDR_POWER: rd_value = {6'h00, st.reg_power};
			dcp_pkg::ADDR_TIMING: rd_value = {5'h00, st.reg_phase, st.reg_dcs};
			dcp_pkg::ADDR_FORMAT: rd_value = {7'h00, st.reg_twos};
			default: rd_value = 8'h00;
		endcase
	end

	// ****************************************
	// sample path: pipeline, buffer, output stage
	// ****************************************
	assign buf_in_valid = enc_rise & active & st.pipe_vld[NP-1];
	assign buf_out_ready = enc_rise & sample_ready;

	dcp_buf2 #(
		.WIDTH(W)
	) u_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(st.pipe[NP-1]),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	always_comb begin
		next_st = st;
		// ****************************************
		// synchronisers
		// ****************************************
		next_st.cs_q = {st.cs_q[0], cs_n};
		next_st.sck_q = {st.sck_q[0], sck};
		next_st.sdi_q = {st.sdi_q[0], sdi};
		next_st.sdo_q = {st.sdo_q[0], sdo_in};
		next_st.encp_q = {st.encp_q[0], encode_in_pos};
		next_st.encn_q = {st.encn_q[0], encode_in_neg};
		next_st.strap_q = {st.strap_q[0], programming_mode_strap};
		next_st.conv_q = {st.conv_q[0], {conv2_ovr, conv1_ovr, conv2_data, conv1_data}};
		next_st.sck_d = sck_lvl;
		next_st.enc_d = enc_lvl;

		// strap is a tie, caught once after reset and then held; the sync chain is
		// cleared by reset, so wait until the pin level has reached its second stage
		if (!st.strap_done) begin
			next_st.strap_cnt = 2'(st.strap_cnt + 2'h1);
			next_st.strap_done = (st.strap_cnt == dcp_pkg::STRAP_SETTLE);
			next_st.par = st.strap_q[1]; // R01 R02
		end

		// ****************************************
		// serial port
		// ****************************************
		if (st.par || !st.strap_done) begin
			next_st.ser = dcp_pkg::SER_IDLE; // R02
			next_st.sdo_low = 1'b0;
		end else if (cs_lvl) begin
			// select high: the port ignores the clock and lets go of the line
			next_st.ser = dcp_pkg::SER_IDLE; // R04
			next_st.bit_cnt = 3'h0;
			next_st.sdo_low = 1'b0;
		end else begin
			if (st.ser == dcp_pkg::SER_IDLE) begin
				next_st.ser = dcp_pkg::SER_CMD;
				next_st.bit_cnt = 3'h0;
			end
			if (sck_rise && st.ser != dcp_pkg::SER_IDLE) begin // R04 R05
				next_st.shift = rx_byte[6:0];
				next_st.bit_cnt = 3'(st.bit_cnt + 3'h1);
				if (st.bit_cnt == dcp_pkg::LAST_BIT) begin
					unique case (st.ser)
						dcp_pkg::SER_CMD: begin
							next_st.addr = rx_byte[6:0];
							next_st.ser = rx_byte[dcp_pkg::RW_BIT] ? dcp_pkg::SER_RD
								: dcp_pkg::SER_WR;
						end
						dcp_pkg::SER_WR: begin
							next_st.ser = dcp_pkg::SER_CMD;
							unique case (st.addr)
								dcp_pkg::ADDR_RESET: begin
									if (rx_byte[dcp_pkg::RESET_BIT]) begin
										next_st.reg_power = dcp_pkg::POWER_RST;
										next_st.reg_dcs = dcp_pkg::DCS_RST;
										next_st.reg_phase = dcp_pkg::PHASE_RST;
										next_st.reg_twos = dcp_pkg::TWOS_RST;
									end
								end
								dcp_pkg::ADDR_POWER: next_st.reg_power = rx_byte[1:0];
								dcp_pkg::ADDR_TIMING: begin
									next_st.reg_dcs = rx_byte[dcp_pkg::DCS_BIT];
									next_st.reg_phase = rx_byte[dcp_pkg::PHASE_LSB+:2]; // R12
								end
								dcp_pkg::ADDR_FORMAT: next_st.reg_twos = rx_byte[dcp_pkg::TWOS_BIT];
								default: begin
								end
							endcase
						end
						default: next_st.ser = dcp_pkg::SER_CMD;
					endcase
				end
			end
			// readback moves on the falling clock edge; unlisted addresses read zero
			if (sck_fall) begin
				if (st.ser == dcp_pkg::SER_RD) begin
					if (st.bit_cnt == 3'h0 && st.sdo_low == 1'b0 && st.rd_shift == 8'h00) begin
						next_st.rd_shift = {rd_value[6:0], 1'b0};
						next_st.sdo_low = ~rd_value[7]; // R06
					end else begin
						next_st.rd_shift = {st.rd_shift[6:0], 1'b0};
						next_st.sdo_low = ~st.rd_shift[7]; // R06
					end
				end else begin
					next_st.sdo_low = 1'b0;
					next_st.rd_shift = 8'h00;
				end
			end
		end

		// ****************************************
		// conversion pipeline, advanced once per encode edge
		// ****************************************
		if (enc_rise) begin
			next_st.pipe[0] = st.conv_q[1]; // R03 R15
			next_st.pipe_vld[0] = active;
			for (int i = 1; i < NP; i++) begin
				next_st.pipe[i] = st.pipe[i-1];
				next_st.pipe_vld[i] = st.pipe_vld[i-1] & active;
			end
			// a full buffer drops the incoming word and says so for one cycle
			next_st.lost = buf_in_valid & ~buf_in_ready;
			if (buf_out_ready) begin
				next_st.out_word = buf_out_data; // R16 R17
				next_st.out_vld = buf_out_valid;
			end
		end else begin
			next_st.lost = 1'b0;
		end

		// ****************************************
		// forwarded clock: tap 0 falls together with the data update; the phase register selects a later tap
		// ****************************************
		next_st.fwd_line[0] = active & ~enc_lvl; // R11
		for (int k = 1; k < dcp_pkg::PHASE_TAPS; k++) begin
			next_st.fwd_line[k] = st.fwd_line[k-1]; // R12
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.ser <= dcp_pkg::SER_IDLE;
			st.reg_power <= dcp_pkg::POWER_RST;
			st.reg_dcs <= dcp_pkg::DCS_RST;
			st.reg_phase <= dcp_pkg::PHASE_RST;
			st.reg_twos <= dcp_pkg::TWOS_RST;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// offset binary by default; two's complement flips the msb on the way out
	assign chan1_sample_bus = {st.out_word[BITS-1] ^ twos_complement,
		st.out_word[BITS-2:0]}; // R14
	assign chan2_sample_bus = {st.out_word[2*BITS-1] ^ twos_complement,
		st.out_word[2*BITS-2:BITS]}; // R14
	assign chan1_overrange_flag = st.out_word[2*BITS]; // R15
	assign chan2_overrange_flag = st.out_word[2*BITS+1]; // R15
	assign sample_valid = st.out_vld;
	assign sample_lost = st.lost;
	assign fwd_out_clock_pos = st.fwd_line[eff_phase]; // R12
	assign fwd_out_clock_neg = ~st.fwd_line[eff_phase]; // R13
	// open drain: the pad only ever pulls low
	assign sdo_out = 1'b0; // R07
	assign sdo_oe = st.sdo_low & ~st.par; // R07

endmodule // dcp_core

//--- src/dcp_pkg.sv
// constants, encodings and register map of the dual converter control and output port
package dcp_pkg;

	// ****************************************
	// data path
	// ****************************************
	localparam int SAMPLE_BITS = 12;
	// encode cycles from a sample edge until the sample shows on the buses
	localparam int LATENCY_CYCLES = 6;
	// the capture edge fills stage 0; buffer entry and output stage take the last two edges
	localparam int PIPE_STAGES = LATENCY_CYCLES - 1;
	// edges after reset release before the strap has crossed its synchroniser
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam int PHASE_TAPS = 4;

	// ****************************************
	// serial frame: one command byte then one data byte, msb first
	// ****************************************
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int RW_BIT = 7;

	// ****************************************
	// mode control registers (7-bit address, 8-bit data)
	// ****************************************
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] ADDR_POWER = 7'h01;
	localparam logic [6:0] ADDR_TIMING = 7'h02;
	localparam logic [6:0] ADDR_FORMAT = 7'h03;
	localparam int RESET_BIT = 7;
	localparam int DCS_BIT = 0;
	localparam int PHASE_LSB = 1;
	localparam int TWOS_BIT = 0;
	localparam logic [1:0] POWER_RST = 2'h0;
	localparam logic DCS_RST = 1'b0;
	localparam logic [1:0] PHASE_RST = 2'h0;
	localparam logic TWOS_RST = 1'b0;

	// power codes, same in both programming modes
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_SLEEP = 2'h3;

	// serial port phase, one-hot
	typedef enum logic [3:0] {
		SER_IDLE = 4'h1,
		SER_CMD = 4'h2,
		SER_WR = 4'h4,
		SER_RD = 4'h8
	} dcp_ser_e;

endpackage

//--- src/dcp_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ns
module dcp_buf2 #(
	parameter int WIDTH = 26
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} dcp_buf2_s;

	dcp_buf2_s st;
	dcp_buf2_s next_st;
	logic push;
	logic pop;

	// full and empty follow the real count, so a stalled drain fills it
	assign in_ready = (st.count != 2'h2);
	assign out_valid = (st.count != 2'h0);
	assign out_data = st.mem[st.rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr = ~st.wr_ptr;
		end
		if (pop) begin
			next_st.rd_ptr = ~st.rd_ptr;
		end
		next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // dcp_buf2

//--- tb/dcp_host.sv
// capture-side partner: pulled-up data-out wire and capture stall
`timescale 1ns/1ns
module dcp_host (
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic drv_en,
	input wire logic drv_val,
	input wire logic stall,
	output logic sdo_in,
	output logic sample_ready
);
	// ****************************************
	// wire resolution
	// ****************************************
	// a released line floats high through the pull-up, never to the last value
	assign sdo_in = drv_en ? drv_val : (sdo_oe ? sdo_out : 1'h1);
	assign sample_ready = !stall;
endmodule // dcp_host

//--- tb/dcp_core_sva.sv
// pin-level assertions on the converter port
`timescale 1ns/1ns
module dcp_core_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_in,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic [11:0] chan1_sample_bus,
	input wire logic [11:0] chan2_sample_bus,
	input wire logic fwd_out_clock_pos,
	input wire logic fwd_out_clock_neg,
	input wire logic sample_lost,
	input wire logic parallel_mode,
	input wire logic dcs_on,
	input wire logic twos_complement,
	input wire logic [1:0] power_state
);
	// ****************************************
	// relations
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// select has to stay high a while: the pin passes a sync chain first
	sequence s_cs_idle; cs_n [*6]; endsequence
	sequence s_new_word;
		parallel_mode && $stable(twos_complement) &&
			($changed(chan1_sample_bus) || $changed(chan2_sample_bus));
	endsequence
	a_fwd_comp: assert property (fwd_out_clock_neg == !fwd_out_clock_pos)
		else $error("forwarded pair not complementary");
	a_drain_only: assert property (sdo_out == 1'h0)
		else $error("data out driven high");
	a_par_quiet: assert property (parallel_mode |-> !sdo_oe)
		else $error("data out pulled in parallel mode");
	a_cs_release: assert property (s_cs_idle |-> !sdo_oe)
		else $error("data out held after deselect");
	a_par_dcs: assert property ((parallel_mode && cs_n) [*5] |-> dcs_on)
		else $error("stabilizer not following select");
	a_par_format: assert property ((parallel_mode && sck) [*5] |-> twos_complement)
		else $error("format not following clock pin");
	a_par_sleep: assert property ((parallel_mode && sdi && sdo_in) [*5] |->
		power_state == dcp_pkg::PWR_SLEEP) else $error("power code not taken");
	a_bus_fall: assert property (s_new_word |-> $fell(fwd_out_clock_pos))
		else $error("buses moved off the clock fall");
	a_lost_pulse: assert property (sample_lost |=> !sample_lost)
		else $error("drop flag longer than one cycle");
	a_sleep_quiet: assert property ((power_state != dcp_pkg::PWR_NORMAL) [*8] |->
		!fwd_out_clock_pos) else $error("forwarded clock runs while down");
endmodule // dcp_core_sva
bind dcp_core dcp_core_sva u_dcp_core_sva (.clk, .sys_rst, .cs_n, .sck, .sdi, .sdo_in,
	.sdo_out, .sdo_oe, .chan1_sample_bus, .chan2_sample_bus, .fwd_out_clock_pos,
	.fwd_out_clock_neg, .sample_lost, .parallel_mode, .dcs_on, .twos_complement, .power_state);

//--- tb/test_dcp_core.sv
// self-checking bench for the converter control and output port
`timescale 1ns/1ns
module test_dcp_core;
	logic clk = 1'h0, sys_rst = 1'h1, strap = 1'h0, enc = 1'h0, cs_n = 1'h1, sck = 1'h0;
	logic sdi = 1'h0, drv_en = 1'h0, drv_val = 1'h0, stall = 1'h0, conv1_ovr, conv2_ovr;
	logic [11:0] conv1_data, conv2_data, held;
	logic sdo_in, sdo_out, sdo_oe, sample_ready, sample_valid, sample_lost;
	logic parallel_mode, dcs_on, twos_complement, chan1_overrange_flag, chan2_overrange_flag;
	logic [11:0] chan1_sample_bus, chan2_sample_bus;
	logic fwd_out_clock_pos, fwd_out_clock_neg;
	logic [1:0] ph = 2'h0;
	logic [1:0] power_state;
	logic [7:0] rd;
	int num_errors = 0, comparisons = 0, cnt = 0, lost = 0, l0;
	dcp_core u_dcp_core (.clk, .sys_rst, .programming_mode_strap(strap), .encode_in_pos(enc),
		.encode_in_neg(~enc), .cs_n, .sck, .sdi, .sdo_in, .sdo_out, .sdo_oe, .conv1_data,
		.conv1_ovr, .conv2_data, .conv2_ovr, .chan1_sample_bus, .chan2_sample_bus,
		.chan1_overrange_flag, .chan2_overrange_flag, .fwd_out_clock_pos,
		.fwd_out_clock_neg, .sample_ready, .sample_valid, .sample_lost, .parallel_mode,
		.dcs_on, .twos_complement, .power_state);
	dcp_host u_dcp_host (.sdo_out, .sdo_oe, .drv_en, .drv_val, .stall, .sdo_in, .sample_ready);
	always #20 clk = ~clk;
	always @(posedge clk) if (sample_lost) lost <= lost + 1;
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic do_reset(input logic s);
		sys_rst <= 1'h1;
		strap <= s;
		cnt = 0;
		conv1_data <= 12'h000;
		conv2_data <= 12'hFFF;
		conv1_ovr <= 1'h0;
		conv2_ovr <= 1'h1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (6) @(posedge clk);
	endtask
	// one 16-bit frame, sck half period of four clocks (160 ns)
	task automatic spi(input logic [15:0] w, output logic [7:0] r);
		r = 8'h00;
		@(posedge clk) cs_n <= 1'h0;
		for (int i = 15; i >= 0; i--) begin
			sdi <= w[i];
			repeat (4) @(posedge clk);
			sck <= 1'h1;
			repeat (4) @(posedge clk);
			if (i < 8) r[i] = sdo_in;
			sck <= 1'h0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'h1;
		repeat (4) @(posedge clk);
	endtask
	// inputs change mid-period, so edge k takes the word set after edge k-1
	task automatic enc_run(input int n, input logic chk, input logic tw);
		logic [11:0] e;
		repeat (n) begin
			@(posedge clk) enc <= 1'h1;
			cnt++;
			repeat (3) @(posedge clk);
			// half a clock after the data update: only an undelayed clock has fallen yet
			@(negedge clk);
			if (chk && cnt > 7) check({fwd_out_clock_pos, fwd_out_clock_neg}, {ph != 2'h0, ph == 2'h0});
			repeat (5) @(posedge clk);
			enc <= 1'h0;
			conv1_data <= cnt[11:0];
			conv2_data <= ~cnt[11:0];
			conv1_ovr <= cnt[0];
			conv2_ovr <= ~cnt[0];
			repeat (2) @(posedge clk);
			e = cnt[11:0] - 12'h007;
			if (chk && cnt > 7) begin
				check(chan1_sample_bus, e ^ {tw, 11'h000});
				check(chan2_sample_bus, 12'(~e ^ {tw, 11'h000}));
				check({chan1_overrange_flag, chan2_overrange_flag}, {e[0], ~e[0]});
			end
			repeat (6) @(posedge clk);
		end
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		do_reset(1'h0);
		spi({1'h0, dcp_pkg::ADDR_FORMAT, 8'h01}, rd);
		check(twos_complement, 1'h1);
		spi({1'h1, dcp_pkg::ADDR_FORMAT, 8'h00}, rd);
		check(rd, 8'h01);
		spi({1'h1, 7'h7F, 8'h00}, rd);
		check(rd, 8'h00);
		spi({1'h0, dcp_pkg::ADDR_TIMING, 8'h05}, rd);
		check(dcs_on, 1'h1);
		spi({1'h1, dcp_pkg::ADDR_TIMING, 8'h00}, rd);
		check(rd, 8'h05);
		ph = 2'h2;
		enc_run(12, 1'h1, 1'h1);
		spi({1'h0, dcp_pkg::ADDR_RESET, 8'h80}, rd);
		check({dcs_on, twos_complement}, 2'h0);
		ph = 2'h0;
		do_reset(1'h1);
		check({parallel_mode, sdo_oe}, 2'h2);
		cs_n <= 1'h1;
		sck <= 1'h1;
		repeat (6) @(posedge clk);
		check({dcs_on, twos_complement}, 2'h3);
		cs_n <= 1'h0;
		sck <= 1'h0;
		drv_en <= 1'h1;
		for (int p = 3; p >= 0; p--) begin
			{sdi, drv_val} <= p[1:0];
			repeat (6) @(posedge clk);
			check(power_state, p[1:0]);
		end
		enc_run(12, 1'h1, 1'h0);
		stall <= 1'h1;
		held = chan1_sample_bus;
		l0 = lost;
		enc_run(6, 1'h0, 1'h0);
		check({chan1_sample_bus, 1'(lost > l0)}, {held, 1'h1});
		stall <= 1'h0;
		enc_run(3, 1'h0, 1'h0);
		check(sample_valid, 1'h1);
		finish_test();
	end
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
endmodule // test_dcp_core
